// file: hdl/memon_top.sv
// mains event monitor: drop, peak and tamper detection with apb registers
//
// Overview of operation
// - eight-bit nominal frequency, reset fifty hertz
// - eight-bit drop cycle limit, reset five
// - count low cycles; limit reached sets flag
// - cycle peak at threshold clears flag, count
// - rms below 0.088 threshold forces drop flag
// - fifteen-bit drop threshold in adc steps
// - report greater channel rms, record direction
// - tamper when greater at least smaller times ratio
// - ratio 1.14 value, 0x4000 to 0x7FFF
// - tamper held zero below current threshold
// - tamper checks only in tamper configuration
// - fifteen-bit tamper current threshold, reset 0x2E
// - voltage peak flag needs three samples above
// - per-channel current peak flags, three samples
// - six-bit dc period count, max 0x32
// - dc off: base uses shorted offset, enhanced zero
// - greater channel drives tamper threshold decision
`include "memon_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module memon_top (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic      [31:0]            prdata,
  output logic                        pslverr,
  input  wire logic                   sample_valid,
  input  wire memon_pkg::memon_sample_t v_sample,
  input  wire memon_pkg::memon_sample_t i1_sample,
  input  wire memon_pkg::memon_sample_t i2_sample,
  input  wire logic                   period_end,
  input  wire logic                   rms_valid,
  input  wire memon_pkg::memon_mag_t  voltage_rms_result,
  input  wire memon_pkg::memon_mag_t  i1_rms,
  input  wire memon_pkg::memon_mag_t  i2_rms,
  input  wire memon_pkg::memon_sample_t shorted_offset_v,
  input  wire memon_pkg::memon_sample_t shorted_offset_i1,
  input  wire memon_pkg::memon_sample_t shorted_offset_i2,
  output logic      [7:0]             nominal_mains_freq,
  output logic      [5:0]             dc_removal_period_count,
  output logic                        voltage_offset_removal_enable,
  output logic                        first_current_offset_removal_enable,
  output logic                        second_current_offset_removal_enable,
  output memon_pkg::memon_sample_t    offset_v,
  output memon_pkg::memon_sample_t    offset_i1,
  output memon_pkg::memon_sample_t    offset_i2,
  output logic                        voltage_drop_flag,
  output logic                        tamper_flag,
  output logic                        second_channel_greater_flag,
  output logic                        voltage_peak_flag,
  output logic      [1:0]             channel_current_peak_flag,
  output memon_pkg::memon_mag_t       reported_current_rms
);

  // absolute value of a signed sample, saturated to 15 bits
  function automatic memon_pkg::memon_mag_t abs_mag(
      input memon_pkg::memon_sample_t s);
    logic [15:0] n;
    n = s[15] ? (~s + 16'h0001) : s;
    abs_mag = n[15] ? 15'h7FFF : n[14:0];
  endfunction

  logic [7:0]  voltage_drop_cycle_limit;
  logic [15:0] tamper_ratio_threshold;
  logic [14:0] tamper_current_threshold;
  logic [14:0] voltage_drop_level;
  logic [14:0] voltage_peak_limit;
  logic [14:0] current_peak_limit;
  logic [4:0]  ctrl;
  logic [7:0]  drop_cnt;
  logic [14:0] cyc_peak;
  logic [1:0]  vrun;
  logic [1:0]  i1run;
  logic [1:0]  i2run;

  logic wr;
  logic rd;
  logic hit;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      `MEMON_OFF_FREQ, `MEMON_OFF_DCYC, `MEMON_OFF_RATIO,
      `MEMON_OFF_TCUR, `MEMON_OFF_DLVL, `MEMON_OFF_VPK,
      `MEMON_OFF_IPK, `MEMON_OFF_DCPER, `MEMON_OFF_CTRL,
      `MEMON_OFF_STAT, `MEMON_OFF_CRMS, `MEMON_OFF_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // parameter registers, range limits on ratio and dc period count only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nominal_mains_freq       <= `MEMON_RST_FREQ;
      voltage_drop_cycle_limit <= `MEMON_RST_DCYC;
      tamper_ratio_threshold   <= `MEMON_RST_RATIO;
      tamper_current_threshold <= `MEMON_RST_TCUR;
      voltage_drop_level       <= `MEMON_RST_DLVL;
      voltage_peak_limit       <= `MEMON_RST_PEAK;
      current_peak_limit       <= `MEMON_RST_PEAK;
      dc_removal_period_count  <= `MEMON_RST_DCPER;
      ctrl                     <= 5'h00;
    end else if (wr) begin
      unique case (paddr)
        `MEMON_OFF_FREQ:  nominal_mains_freq <= pwdata[7:0];
        `MEMON_OFF_DCYC:  voltage_drop_cycle_limit <= pwdata[7:0];
        `MEMON_OFF_RATIO: begin
          if (pwdata[15:0] < `MEMON_RST_RATIO)
            tamper_ratio_threshold <= `MEMON_RST_RATIO;
          else if (pwdata[15:0] > `MEMON_MAX_RATIO)
            tamper_ratio_threshold <= `MEMON_MAX_RATIO;
          else
            tamper_ratio_threshold <= pwdata[15:0];
        end
        `MEMON_OFF_TCUR:  tamper_current_threshold <= pwdata[14:0];
        `MEMON_OFF_DLVL:  voltage_drop_level <= pwdata[14:0];
        `MEMON_OFF_VPK:   voltage_peak_limit <= pwdata[14:0];
        `MEMON_OFF_IPK:   current_peak_limit <= pwdata[14:0];
        `MEMON_OFF_DCPER: begin
          if (pwdata[5:0] > `MEMON_MAX_DCPER)
            dc_removal_period_count <= `MEMON_MAX_DCPER;
          else
            dc_removal_period_count <= pwdata[5:0];
        end
        `MEMON_OFF_CTRL:  ctrl <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  assign voltage_offset_removal_enable        = ctrl[`MEMON_CTRL_DCV];
  assign first_current_offset_removal_enable  = ctrl[`MEMON_CTRL_DCI1];
  assign second_current_offset_removal_enable = ctrl[`MEMON_CTRL_DCI2];

  // offset source when removal is off
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      offset_v  <= 16'h0000;
      offset_i1 <= 16'h0000;
      offset_i2 <= 16'h0000;
    end else begin
      offset_v  <= (ctrl[`MEMON_CTRL_DCV] || ctrl[`MEMON_CTRL_ENH]) ?
                   16'h0000 : shorted_offset_v;
      offset_i1 <= (ctrl[`MEMON_CTRL_DCI1] || ctrl[`MEMON_CTRL_ENH]) ?
                   16'h0000 : shorted_offset_i1;
      offset_i2 <= (ctrl[`MEMON_CTRL_DCI2] || ctrl[`MEMON_CTRL_ENH]) ?
                   16'h0000 : shorted_offset_i2;
    end
  end

  // per-period peak and drop counting
  logic [14:0] next_peak;
  logic        rms_low;
  logic [23:0] rms_scaled;
  always_comb begin
    next_peak = cyc_peak;
    if (sample_valid && abs_mag(v_sample) > cyc_peak)
      next_peak = abs_mag(v_sample);
  end
  assign rms_scaled = voltage_drop_level * `MEMON_RMS_NUM;
  assign rms_low = ({voltage_rms_result, 9'h000} <
                    {rms_scaled});

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cyc_peak <= 15'h0000;
    end else if (period_end) begin
      cyc_peak <= 15'h0000;
    end else begin
      cyc_peak <= next_peak;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      drop_cnt          <= 8'h00;
      voltage_drop_flag <= 1'b0;
    end else begin
      if (period_end) begin
        if (next_peak >= voltage_drop_level) begin
          drop_cnt          <= 8'h00;
          voltage_drop_flag <= 1'b0;
        end else begin
          if (drop_cnt != 8'hFF)
            drop_cnt <= drop_cnt + 8'h01;
          if (drop_cnt + 8'h01 >= voltage_drop_cycle_limit ||
              drop_cnt == 8'hFF)
            voltage_drop_flag <= 1'b1;
        end
      end
      if (rms_valid && rms_low)
        voltage_drop_flag <= 1'b1;
    end
  end

  // rms compare, direction and tamper
  logic        i2_gt;
  logic [14:0] hi_rms;
  logic [14:0] lo_rms;
  logic [30:0] lo_scaled;
  assign i2_gt     = i2_rms > i1_rms;
  assign hi_rms    = i2_gt ? i2_rms : i1_rms;
  assign lo_rms    = i2_gt ? i1_rms : i2_rms;
  assign lo_scaled = lo_rms * tamper_ratio_threshold;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      second_channel_greater_flag <= 1'b0;
      reported_current_rms        <= 15'h0000;
      tamper_flag                 <= 1'b0;
    end else if (rms_valid) begin
      second_channel_greater_flag <= i2_gt;
      reported_current_rms        <= hi_rms;
      if (!ctrl[`MEMON_CTRL_TAMPER])
        tamper_flag <= 1'b0;
      else if (hi_rms < tamper_current_threshold)
        tamper_flag <= 1'b0;
      else
        tamper_flag <= ({2'b00, hi_rms, 14'h0000} >= lo_scaled);
    end
  end

  // spike filters need three contiguous samples above level
  function automatic logic [1:0] run_step(input logic [1:0] r,
                                          input logic above);
    run_step = !above ? 2'h0 : (r == `MEMON_PEAK_RUN ? r : r + 2'h1);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vrun  <= 2'h0;
      i1run <= 2'h0;
      i2run <= 2'h0;
    end else if (sample_valid) begin
      vrun  <= run_step(vrun, abs_mag(v_sample) > voltage_peak_limit);
      i1run <= run_step(i1run, abs_mag(i1_sample) > current_peak_limit);
      i2run <= run_step(i2run, abs_mag(i2_sample) > current_peak_limit);
    end
  end
  assign voltage_peak_flag            = (vrun == `MEMON_PEAK_RUN);
  assign channel_current_peak_flag[0] = (i1run == `MEMON_PEAK_RUN);
  assign channel_current_peak_flag[1] = (i2run == `MEMON_PEAK_RUN);

  // read mux
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (paddr)
        `MEMON_OFF_FREQ:  prdata <= {24'h00_0000, nominal_mains_freq};
        `MEMON_OFF_DCYC:  prdata <= {24'h00_0000, voltage_drop_cycle_limit};
        `MEMON_OFF_RATIO: prdata <= {16'h0000, tamper_ratio_threshold};
        `MEMON_OFF_TCUR:  prdata <= {17'h0_0000, tamper_current_threshold};
        `MEMON_OFF_DLVL:  prdata <= {17'h0_0000, voltage_drop_level};
        `MEMON_OFF_VPK:   prdata <= {17'h0_0000, voltage_peak_limit};
        `MEMON_OFF_IPK:   prdata <= {17'h0_0000, current_peak_limit};
        `MEMON_OFF_DCPER: prdata <= {26'h000_0000, dc_removal_period_count};
        `MEMON_OFF_CTRL:  prdata <= {27'h000_0000, ctrl};
        `MEMON_OFF_STAT:  prdata <= {26'h000_0000,
                                     channel_current_peak_flag,
                                     voltage_peak_flag,
                                     second_channel_greater_flag,
                                     tamper_flag, voltage_drop_flag};
        `MEMON_OFF_CRMS:  prdata <= {17'h0_0000, reported_current_rms};
        `MEMON_OFF_OFS:   prdata <= {offset_i1, offset_v};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  property p_drop_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      period_end && next_peak >= voltage_drop_level && !(rms_valid && rms_low)
      |=> !voltage_drop_flag && drop_cnt == 8'h00;
  endproperty
  a_drop_clear: assert property (p_drop_clear) else $error("drop clear");

  property p_drop_set;
    @(posedge clk_sys) disable iff (!rst_n)
      period_end && next_peak < voltage_drop_level &&
      drop_cnt + 8'h01 >= voltage_drop_cycle_limit |=> voltage_drop_flag;
  endproperty
  a_drop_set: assert property (p_drop_set) else $error("drop set");

  property p_rms_force;
    @(posedge clk_sys) disable iff (!rst_n)
      rms_valid && rms_low |=> voltage_drop_flag;
  endproperty
  a_rms_force: assert property (p_rms_force) else $error("rms force");

  property p_tamp_gate;
    @(posedge clk_sys) disable iff (!rst_n)
      rms_valid && (!ctrl[`MEMON_CTRL_TAMPER] ||
                    hi_rms < tamper_current_threshold) |=> !tamper_flag;
  endproperty
  a_tamp_gate: assert property (p_tamp_gate) else $error("tamper gate");

  property p_dir;
    @(posedge clk_sys) disable iff (!rst_n)
      rms_valid |=> second_channel_greater_flag == $past(i2_rms > i1_rms)
        && reported_current_rms >= $past(i1_rms);
  endproperty
  a_dir: assert property (p_dir) else $error("direction");

  property p_vpk;
    @(posedge clk_sys) disable iff (!rst_n)
      sample_valid && abs_mag(v_sample) <= voltage_peak_limit
      |=> !voltage_peak_flag;
  endproperty
  a_vpk: assert property (p_vpk) else $error("vpeak");

  property p_ipk;
    @(posedge clk_sys) disable iff (!rst_n)
      sample_valid && abs_mag(i1_sample) <= current_peak_limit
      |=> !channel_current_peak_flag[0];
  endproperty
  a_ipk: assert property (p_ipk) else $error("ipeak");

  property p_ratio;
    @(posedge clk_sys) disable iff (!rst_n)
      tamper_ratio_threshold >= `MEMON_RST_RATIO &&
      tamper_ratio_threshold <= `MEMON_MAX_RATIO;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio range");

  property p_dcper;
    @(posedge clk_sys) disable iff (!rst_n)
      dc_removal_period_count <= `MEMON_MAX_DCPER;
  endproperty
  a_dcper: assert property (p_dcper) else $error("dc period");

  c_drop: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(voltage_drop_flag));
  c_tamp: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(tamper_flag));
  c_vpk: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(voltage_peak_flag));

endmodule
`default_nettype wire

// file: hdl/memon_defines.svh
// constants for the mains event monitor: offsets, resets, field positions
`ifndef MEMON_DEFINES_SVH
`define MEMON_DEFINES_SVH
`define MEMON_OFF_FREQ     12'h000
`define MEMON_OFF_DCYC     12'h004
`define MEMON_OFF_RATIO    12'h008
`define MEMON_OFF_TCUR     12'h00C
`define MEMON_OFF_DLVL     12'h010
`define MEMON_OFF_VPK      12'h014
`define MEMON_OFF_IPK      12'h018
`define MEMON_OFF_DCPER    12'h01C
`define MEMON_OFF_CTRL     12'h020
`define MEMON_OFF_STAT     12'h024
`define MEMON_OFF_CRMS     12'h028
`define MEMON_OFF_OFS      12'h02C
`define MEMON_RST_FREQ     8'h32
`define MEMON_RST_DCYC     8'h05
`define MEMON_RST_RATIO    16'h4000
`define MEMON_MAX_RATIO    16'h7FFF
`define MEMON_RST_TCUR     15'h002E
`define MEMON_RST_DLVL     15'h0000
`define MEMON_RST_PEAK     15'h7FFF
`define MEMON_RST_DCPER    6'h05
`define MEMON_MAX_DCPER    6'h32
`define MEMON_RATIO_SHIFT  14
// 0.088 approximated as 45/512
`define MEMON_RMS_NUM      9'h02D
`define MEMON_RMS_SHIFT    9
`define MEMON_PEAK_RUN     2'h3
`define MEMON_CTRL_TAMPER  0
`define MEMON_CTRL_DCV     1
`define MEMON_CTRL_DCI1    2
`define MEMON_CTRL_DCI2    3
`define MEMON_CTRL_ENH     4
`define MEMON_ST_VDROP     0
`define MEMON_ST_TAMP      1
`define MEMON_ST_DIR       2
`define MEMON_ST_VPK       3
`define MEMON_ST_I1PK      4
`define MEMON_ST_I2PK      5
`endif

// file: hdl/memon_pkg.sv
// types for the mains event monitor
package memon_pkg;
  typedef logic [15:0] memon_sample_t;
  typedef logic [14:0] memon_mag_t;
endpackage

// file: test/tb.sv
// self-checking testbench for the mains event monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                     clk_sys, rst_n, psel, penable, pwrite, pready;
  logic                     pslverr, err, sample_valid, period_end, rms_valid;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, rd;
  memon_pkg::memon_sample_t v_s, i1_s, i2_s, sv, si1, si2, o_v, o_i1, o_i2;
  memon_pkg::memon_mag_t    v_rms, i1_rms, i2_rms, cur_rms;
  logic [7:0]               freq;
  logic [5:0]               dcper;
  logic                     en_v, en_i1, en_i2, drop, tamp, dir, vpk;
  logic [1:0]               ipk;
  int                       bad_count, check_count;

  memon_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .v_sample(v_s), .i1_sample(i1_s),
    .i2_sample(i2_s), .period_end(period_end), .rms_valid(rms_valid),
    .voltage_rms_result(v_rms), .i1_rms(i1_rms), .i2_rms(i2_rms),
    .shorted_offset_v(sv), .shorted_offset_i1(si1), .shorted_offset_i2(si2),
    .nominal_mains_freq(freq), .dc_removal_period_count(dcper),
    .voltage_offset_removal_enable(en_v),
    .first_current_offset_removal_enable(en_i1),
    .second_current_offset_removal_enable(en_i2),
    .offset_v(o_v), .offset_i1(o_i1), .offset_i2(o_i2),
    .voltage_drop_flag(drop), .tamper_flag(tamp),
    .second_channel_greater_flag(dir), .voltage_peak_flag(vpk),
    .channel_current_peak_flag(ipk), .reported_current_rms(cur_rms));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic smp(input logic [15:0] v, i1, i2, input logic pe);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    period_end <= pe;
    v_s <= v;
    i1_s <= i1;
    i2_s <= i2;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    period_end <= 1'b0;
    #1;
  endtask

  task automatic rms(input logic [14:0] v, i1, i2);
    @(posedge clk_sys);
    rms_valid <= 1'b1;
    v_rms <= v;
    i1_rms <= i1;
    i2_rms <= i2;
    @(posedge clk_sys);
    rms_valid <= 1'b0;
    #1;
  endtask

  task automatic t_regs;
    logic [31:0] exp [8];
    exp = '{32'h0000_0032, 32'h0000_0005, 32'h0000_4000, 32'h0000_002E,
            32'h0000_0000, 32'h0000_7FFF, 32'h0000_7FFF, 32'h0000_0005};
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0000_0000);
      chk(rd, exp[k]);
    end
    chk(32'(freq), 32'h0000_0032);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h0000_1234);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_4000);
    apb(1'b1, 12'h008, 32'h0000_FFFF);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_7FFF);
    apb(1'b1, 12'h01C, 32'h0000_003F);
    chk(32'(dcper), 32'h0000_0032);
    apb(1'b1, 12'h000, 32'h0000_003C);
    chk(32'(freq), 32'h0000_003C);
    $display("done: registers");
  endtask

  task automatic t_drop;
    apb(1'b1, 12'h010, 32'h0000_0100);
    apb(1'b1, 12'h004, 32'h0000_0002);
    smp(16'h0050, 16'h0000, 16'h0000, 1'b1);
    chk(32'(drop), 32'h0000_0000);
    smp(16'hFFB0, 16'h0000, 16'h0000, 1'b1);
    chk(32'(drop), 32'h0000_0001);
    smp(16'hFE00, 16'h0000, 16'h0000, 1'b1);
    chk(32'(drop), 32'h0000_0000);
    smp(16'h0050, 16'h0000, 16'h0000, 1'b1);
    chk(32'(drop), 32'h0000_0000);
    smp(16'h0050, 16'h0000, 16'h0000, 1'b1);
    chk(32'(drop), 32'h0000_0001);
    smp(16'h0100, 16'h0000, 16'h0000, 1'b1);
    chk(32'(drop), 32'h0000_0000);
    // 45/512 of 0x100 is 22.5
    rms(15'd30, 15'd0, 15'd0);
    chk(32'(drop), 32'h0000_0000);
    rms(15'd20, 15'd0, 15'd0);
    chk(32'(drop), 32'h0000_0001);
    // peak of a two-sample period is kept until its end
    smp(16'h0200, 16'h0000, 16'h0000, 1'b0);
    smp(16'h0050, 16'h0000, 16'h0000, 1'b1);
    chk(32'(drop), 32'h0000_0000);
    smp(16'h0100, 16'h0000, 16'h0000, 1'b1);
    $display("done: voltage drop");
  endtask

  task automatic t_tamper;
    apb(1'b1, 12'h020, 32'h0000_0001);
    rms(15'h7000, 15'd1000, 15'd500);
    chk(32'({tamp, dir, cur_rms}), 32'h0001_0000 | 32'd1000);
    apb(1'b1, 12'h008, 32'h0000_6000);
    rms(15'h7000, 15'd700, 15'd500);
    chk(32'(tamp), 32'h0000_0000);
    rms(15'h7000, 15'd750, 15'd500);
    chk(32'(tamp), 32'h0000_0001);
    rms(15'h7000, 15'd100, 15'd800);
    chk(32'({tamp, dir, cur_rms}), 32'h0001_8000 | 32'd800);
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    rms(15'h7000, 15'd45, 15'd10);
    chk(32'(tamp), 32'h0000_0000);
    rms(15'h7000, 15'd46, 15'd10);
    chk(32'(tamp), 32'h0000_0001);
    apb(1'b1, 12'h020, 32'h0000_0000);
    rms(15'h7000, 15'd1000, 15'd10);
    chk(32'({tamp, cur_rms}), 32'd1000);
    $display("done: tamper");
  endtask

  task automatic t_peak;
    apb(1'b1, 12'h014, 32'h0000_0100);
    apb(1'b1, 12'h018, 32'h0000_0100);
    smp(16'h0200, 16'h0200, 16'h0050, 1'b0);
    smp(16'h0200, 16'h0200, 16'h0050, 1'b0);
    smp(16'h0050, 16'h0200, 16'h0100, 1'b0);
    chk(32'({vpk, ipk}), 32'h0000_0001);
    smp(16'hFE00, 16'h0050, 16'hFE00, 1'b0);
    smp(16'hFE00, 16'h0050, 16'hFE00, 1'b0);
    chk(32'({vpk, ipk}), 32'h0000_0000);
    smp(16'hFE00, 16'h0050, 16'hFE00, 1'b0);
    chk(32'({vpk, ipk}), 32'h0000_0006);
    $display("done: peaks");
  endtask

  task automatic t_offset;
    apb(1'b1, 12'h020, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({o_i1, o_v}, 32'h0456_0123);
    chk(32'(o_i2), 32'h0000_0789);
    apb(1'b1, 12'h020, 32'h0000_000A);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'({en_v, en_i1, en_i2, o_i2}), 32'h0005_0000);
    apb(1'b0, 12'h02C, 32'h0000_0000);
    chk(rd, 32'h0456_0000);
    apb(1'b1, 12'h020, 32'h0000_0010);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({o_i1, o_v}, 32'h0000_0000);
    chk(32'(o_i2), 32'h0000_0000);
    $display("done: offsets");
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, sample_valid, period_end, rms_valid} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {v_s, i1_s, i2_s} = 48'h0000_0000_0000;
    {v_rms, i1_rms, i2_rms} = 45'h0000_0000_0000;
    sv = 16'h0123;
    si1 = 16'h0456;
    si2 = 16'h0789;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs;
    t_drop;
    t_tamper;
    t_peak;
    t_offset;
    final_report;
  end

  // cuts a hang short well past the expected run of under two hundred cycles
  initial begin
    #200000;
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
